// [rtl/link_if.sv]
// synchronised link levels and edge pulses between sampler and core
`timescale 1ns/1ps
interface link_if #(parameter int N_PINS = 12);
	logic              cs_n;
	logic              sdi;
	logic [N_PINS-1:0] pins;
	logic              cs_fall;
	logic              cs_rise;
	logic              sclk_rise;
	logic              sclk_fall;
	modport sync_src (output cs_n, sdi, pins, cs_fall, cs_rise, sclk_rise, sclk_fall);
	modport core_sink (input cs_n, sdi, pins, cs_fall, cs_rise, sclk_rise, sclk_fall);
endinterface : link_if

// [rtl/pin_sync.sv]
// two-flop sampling of the serial pins and parallel inputs, with edge detection
`timescale 1ns/1ps
module pin_sync #(
	parameter int N_PINS = 12
) (
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_cs_n,
	input  wire logic              i_sclk,
	input  wire logic              i_sdi,
	input  wire logic [N_PINS-1:0] i_pins,
	link_if.sync_src               link
);
	localparam int W = N_PINS + serial_cmd_pkg::LINE_W;
	localparam logic [W-1:0] RST_V = {{N_PINS{1'b0}}, serial_cmd_pkg::LINE_IDLE};

	logic [W-1:0] meta_q, meta_d;
	logic [W-1:0] sync_q, sync_d;
	logic [W-1:0] last_q, last_d;

	always_comb begin
		meta_d = {i_pins, i_sdi, i_sclk, i_cs_n};
		sync_d = meta_q;
		last_d = sync_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= RST_V;
			sync_q <= RST_V;
			last_q <= RST_V;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	assign link.cs_n      = sync_q[0];
	assign link.sdi       = sync_q[2];
	assign link.pins      = sync_q[W-1:3];
	assign link.cs_fall   = ~sync_q[0] & last_q[0];
	assign link.cs_rise   = sync_q[0] & ~last_q[0];
	assign link.sclk_rise = sync_q[1] & ~last_q[1];
	assign link.sclk_fall = ~sync_q[1] & last_q[1];
endmodule : pin_sync

// [rtl/serial_cmd_pkg.sv]
// shared constants of the serial command port
package serial_cmd_pkg;
	localparam int        WORD_W     = 16;
	localparam int        CNT_W      = 5;
	localparam int        ADDR_W     = 4;
	localparam int        DATA_LSB   = 4;
	localparam int        N_PINS     = 12;
	localparam int        N_DAC      = 12;
	localparam int        DAC_W      = 8;
	localparam int        LINE_W     = 3;
	localparam logic [4:0] CNT_ZERO  = 5'h00;
	localparam logic [4:0] CNT_FULL  = 5'h10;
	localparam logic [4:0] CNT_OVER  = 5'h11;
	localparam logic [3:0] OP_NOP    = 4'h0;
	localparam logic [3:0] OP_DAC_LO = 4'h1;
	localparam logic [3:0] OP_DAC_HI = 4'hC;
	localparam logic [3:0] OP_POUT   = 4'hD;
	localparam logic [3:0] OP_XSTATE = 4'hE;
	localparam logic [3:0] OP_READ   = 4'hF;
	localparam logic [3:0] LOW_FILL  = 4'h0;
	localparam logic [2:0] LINE_IDLE = 3'h3;
	localparam logic [7:0] DAC_RST   = 8'h00;
	localparam logic [11:0] POUT_RST = 12'h000;
	localparam logic [11:0] MODE_RST = 12'h000;
	localparam logic [15:0] WORD_RST = 16'h0000;
endpackage : serial_cmd_pkg

// [rtl/serial_cmd_port.sv]
// chip-select framed serial command port driving converter codes and the I/O expander
//
// Overview of operation
// - frame opens on chip select falling, bits taken while low
// - one 16-bit word per frame, executed at rise
// - converter command loads selected channel code at rise
// - parallel output command updates outputs at rise
// - state register write sets pin directions at rise
// - read request captured; pins loaded at next fall
// - readback bits driven out on serial clock falls
`timescale 1ns/1ps
module serial_cmd_port #(
	parameter int N_PINS = serial_cmd_pkg::N_PINS,
	parameter int N_DAC  = serial_cmd_pkg::N_DAC,
	parameter int DAC_W  = serial_cmd_pkg::DAC_W
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_cs_n,
	input  wire logic                   i_sclk,
	input  wire logic                   i_sdi,
	input  wire logic [N_PINS-1:0]      i_pin_in,
	output logic                        o_sdo,
	output logic                        o_sdo_oe,
	output logic      [N_PINS-1:0]      o_pin_out,
	output logic      [N_PINS-1:0]      o_pin_oe,
	output logic      [N_DAC*DAC_W-1:0] o_dac_code
);
	localparam int WW = serial_cmd_pkg::WORD_W;
	localparam int DL = serial_cmd_pkg::DATA_LSB;
	localparam int AW = serial_cmd_pkg::ADDR_W;

	link_if #(.N_PINS(N_PINS)) link ();

	pin_sync #(.N_PINS(N_PINS)) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_cs_n    (i_cs_n),
		.i_sclk    (i_sclk),
		.i_sdi     (i_sdi),
		.i_pins    (i_pin_in),
		.link      (link)
	);

	logic [WW-1:0]                 shift_q, shift_d;
	logic [serial_cmd_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [N_DAC-1:0][DAC_W-1:0]   dac_q, dac_d;
	logic [N_PINS-1:0]             pout_q, pout_d;
	logic [N_PINS-1:0]             xstate_q, xstate_d;
	logic                          req_q, req_d;
	logic                          rd_q, rd_d;
	logic                          sdo_q, sdo_d;

	logic [serial_cmd_pkg::ADDR_W-1:0] op;
	logic [serial_cmd_pkg::ADDR_W-1:0] dac_idx;
	logic                          word_ok;
	logic                          exec_dac;

	assign op       = shift_q[serial_cmd_pkg::ADDR_W-1:0];
	assign dac_idx  = op - serial_cmd_pkg::OP_DAC_LO;
	assign word_ok  = link.cs_rise && (cnt_q == serial_cmd_pkg::CNT_FULL);
	assign exec_dac = word_ok && (op >= serial_cmd_pkg::OP_DAC_LO) && (op <= serial_cmd_pkg::OP_DAC_HI);

	// per-channel code update
	genvar g;
	generate
		for (g = 0; g < N_DAC; g = g + 1) begin : g_dac
			always_comb begin
				if (exec_dac && (dac_idx == AW'(g))) begin
					dac_d[g] = shift_q[DL+DAC_W-1:DL];
				end else begin
					dac_d[g] = dac_q[g];
				end
			end
		end
	endgenerate

	always_comb begin
		shift_d = shift_q;
		cnt_d   = cnt_q;
		pout_d  = pout_q;
		xstate_d = xstate_q;
		req_d   = req_q;
		rd_d    = rd_q;
		sdo_d   = sdo_q;
		if (link.cs_fall) begin
			cnt_d = serial_cmd_pkg::CNT_ZERO;
			rd_d  = req_q;
			req_d = 1'b0;
			if (req_q) begin
				shift_d = {link.pins, serial_cmd_pkg::LOW_FILL};
				sdo_d   = link.pins[N_PINS-1];
			end
		end else if (!link.cs_n && link.sclk_rise) begin
			shift_d = {shift_q[WW-2:0], link.sdi};
			if (cnt_q != serial_cmd_pkg::CNT_OVER) begin
				cnt_d = cnt_q + 5'h01;
			end
		end
		if (rd_q && !link.cs_n && link.sclk_fall) begin
			sdo_d = shift_q[WW-1];
		end
		if (link.cs_rise) begin
			rd_d = 1'b0;
		end
		if (word_ok) begin
			case (op)
				serial_cmd_pkg::OP_POUT: pout_d = shift_q[WW-1:DL];
				serial_cmd_pkg::OP_XSTATE: xstate_d = shift_q[WW-1:DL];
				serial_cmd_pkg::OP_READ: req_d  = 1'b1;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			shift_q <= serial_cmd_pkg::WORD_RST;
			cnt_q   <= serial_cmd_pkg::CNT_ZERO;
			dac_q   <= {N_DAC{serial_cmd_pkg::DAC_RST}};
			pout_q  <= serial_cmd_pkg::POUT_RST;
			xstate_q <= serial_cmd_pkg::MODE_RST;
			req_q   <= 1'b0;
			rd_q    <= 1'b0;
			sdo_q   <= 1'b0;
		end else begin
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			dac_q   <= dac_d;
			pout_q  <= pout_d;
			xstate_q <= xstate_d;
			req_q   <= req_d;
			rd_q    <= rd_d;
			sdo_q   <= sdo_d;
		end
	end

	assign o_sdo      = sdo_q;
	assign o_sdo_oe   = rd_q & ~link.cs_n;
	assign o_pin_out  = pout_q;
	assign o_pin_oe   = xstate_q;
	assign o_dac_code = dac_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_word_taken;
		link.cs_rise && (cnt_q == serial_cmd_pkg::CNT_FULL);
	endsequence
	sequence s_readback_open;
		link.cs_fall && req_q;
	endsequence

	a_shift_idle_hold: assert property (link.cs_n |=> $stable(shift_q))
		else $error("shift register moved while chip select high");
	sequence s_bit_taken;
		!link.cs_n && link.sclk_rise && !link.cs_fall;
	endsequence
	sequence s_bit_driven;
		rd_q && !link.cs_n && link.sclk_fall;
	endsequence

	// framing and bit count
	a_bit_count_step: assert property (
		s_bit_taken ##0 (cnt_q < serial_cmd_pkg::CNT_OVER) |=> cnt_q == $past(cnt_q) + 5'h01)
		else $error("bit count did not advance");
	a_count_clear: assert property (
		link.cs_fall |=> cnt_q == serial_cmd_pkg::CNT_ZERO)
		else $error("bit count not cleared at frame start");
	a_count_hold: assert property (
		link.cs_n |=> $stable(cnt_q))
		else $error("bit count moved while chip select high");
	a_count_sat: assert property (
		(cnt_q == serial_cmd_pkg::CNT_OVER) && !link.cs_fall |=> cnt_q == serial_cmd_pkg::CNT_OVER)
		else $error("bit count left saturation inside a frame");
	a_short_word_drop: assert property (
		link.cs_rise && (cnt_q != serial_cmd_pkg::CNT_FULL)
		|=> $stable(xstate_q) && $stable(pout_q) && $stable(dac_q) && !req_q)
		else $error("frame of wrong length was executed");

	// command execution
	a_dac_load: assert property (
		exec_dac |=> dac_q[$past(dac_idx)] == $past(shift_q[DL+DAC_W-1:DL]))
		else $error("converter code not loaded");
	a_dac_hold: assert property (
		!exec_dac |=> $stable(dac_q))
		else $error("converter code changed without command");
	a_pout_load: assert property (
		s_word_taken ##0 (op == serial_cmd_pkg::OP_POUT)
		|=> pout_q == $past(shift_q[WW-1:DL]))
		else $error("parallel outputs not updated");
	a_pout_hold: assert property (
		!(word_ok && (op == serial_cmd_pkg::OP_POUT)) |=> $stable(pout_q))
		else $error("parallel outputs changed without command");
	a_mode_load: assert property (
		s_word_taken ##0 (op == serial_cmd_pkg::OP_XSTATE)
		|=> o_pin_oe == $past(shift_q[WW-1:DL]))
		else $error("state register not written");
	a_mode_hold: assert property (
		!(word_ok && (op == serial_cmd_pkg::OP_XSTATE)) |=> $stable(o_pin_oe))
		else $error("pin directions changed without command");
	a_req_capture: assert property (
		s_word_taken ##0 (op == serial_cmd_pkg::OP_READ) |=> req_q)
		else $error("read request not captured");
	a_req_consume: assert property (
		link.cs_fall |=> !req_q)
		else $error("read request outlived the frame start");

	// readback and serial timing
	a_pin_load: assert property (
		s_readback_open |=> (shift_q[WW-1:DL] == $past(link.pins)) && rd_q)
		else $error("parallel inputs not loaded at frame start");
	a_sdo_preload: assert property (
		s_readback_open |=> o_sdo == $past(link.pins[N_PINS-1]))
		else $error("first readback bit not presented");
	a_sdo_follow: assert property (
		s_bit_driven |=> o_sdo == $past(shift_q[WW-1]))
		else $error("serial output did not follow shift register");
	a_sdo_hold: assert property (
		!(rd_q && !link.cs_n && link.sclk_fall) && !(link.cs_fall && req_q)
		|=> $stable(o_sdo))
		else $error("serial output changed off a clock fall");
	a_oe_close: assert property (
		link.cs_rise |=> !o_sdo_oe)
		else $error("serial output still driven after frame end");
	a_sample_rise: assert property (
		s_bit_taken |=> shift_q[0] == $past(link.sdi))
		else $error("serial input not sampled on clock rise");
	a_bit_shift: assert property (
		s_bit_taken |=> shift_q[WW-1:1] == $past(shift_q[WW-2:0]))
		else $error("shift register did not move by one bit");
	a_shift_rise_only: assert property (
		!link.cs_n && !link.sclk_rise && !link.cs_fall |=> $stable(shift_q))
		else $error("shift register moved off a clock rise");
endmodule : serial_cmd_port

// [tb/host_model.sv]
// host side of the chip-select serial link, driven off the falling clock edge
`timescale 1ns/1ps
module host_model (
	input  wire logic i_clk,
	input  wire logic i_sdo,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_sdi
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_sdi  = 1'b0;
	end
	task automatic half_wait(input int n);
		repeat (n * 4) @(negedge i_clk);
	endtask : half_wait
	// one frame, msb first; readback sampled just before each clock rise
	task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd);
		rd = 16'h0000;
		o_cs_n = 1'b0;
		half_wait(2);
		for (int i = 0; i < nbits; i++) begin
			o_sclk = 1'b0;
			o_sdi  = w[15-i];
			half_wait(1);
			rd     = {rd[14:0], i_sdo};
			o_sclk = 1'b1;
			half_wait(1);
		end
		o_cs_n = 1'b1;
		o_sdi  = ~o_sdi;
		half_wait(2);
	endtask : xfer
endmodule : host_model

// [tb/serial_cmd_port_tb.sv]
// self-checking bench of the serial command port
`timescale 1ns/1ps
module serial_cmd_port_tb;
	logic        i_clk;
	logic        i_sys_rst;
	logic        cs_n;
	logic        sclk;
	logic        sdi;
	logic [11:0] pin_in;
	logic        sdo;
	logic        sdo_line;
	logic        sdo_oe;
	logic [11:0] pin_out;
	logic [11:0] pin_oe;
	logic [95:0] dac_code;
	logic [95:0] dac_exp;
	logic [15:0] rd;
	int          fail_count;
	int          num_checks;
	int          cycles;

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	serial_cmd_port i_serial_cmd_port (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_sdi(sdi), .i_pin_in(pin_in), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_pin_out(pin_out),
		.o_pin_oe(pin_oe), .o_dac_code(dac_code));
	// undriven data line reads inverted
	assign sdo_line = sdo_oe ? sdo : ~sdo;
	host_model i_host_model (.i_clk(i_clk), .i_sdo(sdo_line), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic t_dac();
		for (int ch = 1; ch <= 12; ch++) begin
			dac_exp[ch*8-1 -: 8] = 8'hF0 + 8'(ch);
			i_host_model.xfer({4'h0, 8'hF0 + 8'(ch), 4'(ch)}, 16, rd);
			chk(dac_code, dac_exp);
		end
	endtask : t_dac

	task automatic t_pout();
		i_host_model.xfer({12'hA5C, serial_cmd_pkg::OP_POUT}, 16, rd);
		chk(pin_out, 12'hA5C);
		i_host_model.xfer({12'h5A3, serial_cmd_pkg::OP_POUT}, 16, rd);
		chk(pin_out, 12'h5A3);
		i_host_model.xfer({12'h0FF, serial_cmd_pkg::OP_POUT}, 15, rd);
		chk(pin_out, 12'h5A3);
		chk(pin_oe, 12'h000);
	endtask : t_pout

	task automatic t_pin_mode();
		i_host_model.xfer({12'hC35, serial_cmd_pkg::OP_XSTATE}, 16, rd);
		chk(pin_oe, 12'hC35);
		chk(pin_out, 12'h5A3);
	endtask : t_pin_mode

	// back-to-back readback: the first readback word is itself a new request, the second is a no-op
	task automatic t_read();
		i_host_model.xfer({12'h000, serial_cmd_pkg::OP_READ}, 16, rd);
		chk(sdo_oe, 1'b0);
		pin_in = 12'h9B6;
		i_host_model.xfer({12'h000, serial_cmd_pkg::OP_READ}, 16, rd);
		chk(rd, {12'h9B6, 4'h0});
		pin_in = 12'h46D;
		i_host_model.xfer({12'h000, serial_cmd_pkg::OP_NOP}, 16, rd);
		chk(rd, {12'h46D, 4'h0});
		chk(dac_code, dac_exp);
	endtask : t_read

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 10000) begin
			fail_count++;
			end_sim();
		end
	end

	initial begin
		i_sys_rst = 1'b1;
		pin_in = 12'h000;
		dac_exp = '0;
		fail_count = 0;
		num_checks = 0;
		cycles = 0;
		repeat (20) @(negedge i_clk);
		i_sys_rst = 1'b0;
		chk(dac_code, dac_exp);
		chk({pin_out, pin_oe, sdo_oe}, 25'h000_0000);
		t_dac();
		t_pout();
		t_pin_mode();
		t_read();
		end_sim();
	end
endmodule : serial_cmd_port_tb
